// *** inc/tcpm_map.svh ***
`ifndef TCPM_MAP_SVH
`define TCPM_MAP_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TCPM_OFF_CFG 8'h00
`define TCPM_OFF_AMR 8'h04
`define TCPM_OFF_BMR 8'h08
`define TCPM_OFF_CTL 8'h0c
`define TCPM_OFF_IMR 8'h18
`define TCPM_OFF_RIS 8'h1c
`define TCPM_OFF_MIS 8'h20
`define TCPM_OFF_ICR 8'h24
// Paired registers: half A at base, half B at base + 4
`define TCPM_OFF_ILR 8'h28
`define TCPM_OFF_MT 8'h30
`define TCPM_OFF_PR 8'h38
`define TCPM_OFF_PMR 8'h40
`define TCPM_OFF_TR 8'h48
`define TCPM_OFF_TV 8'h50
`define TCPM_PAIR_MASK 8'hf8
// ----------------------------------------
// Control fields, per half shifted by HALF, except the RTC stall override (half A only)
// ----------------------------------------
`define TCPM_CTL_HALF 8
`define TCPM_CTL_EN 0
`define TCPM_CTL_STALL 1
`define TCPM_CTL_EVT 2
`define TCPM_CTL_RTC_STALL_OVERRIDE_BIT 4
`define TCPM_CTL_OTE 5
`define TCPM_CTL_PWML 6
// ----------------------------------------
// Status fields, per half shifted by HALF, except RTC (half A only)
// ----------------------------------------
`define TCPM_ST_TO 0
`define TCPM_ST_CM 1
`define TCPM_ST_CE 2
`define TCPM_ST_RTC 3
// ----------------------------------------
// Mode field values and reset values
// ----------------------------------------
`define TCPM_MR_ONESHOT 2'h1
`define TCPM_MR_PERIODIC 2'h2
`define TCPM_MR_CAPTURE 2'h3
`define TCPM_RST_CNT 16'hffff
`define TCPM_RST_PR 8'h00
`define TCPM_RTC_FIRST 32'h00000001
// ----------------------------------------
// Slow clock rising edges per RTC second
// ----------------------------------------
`define TCPM_RTC_DIV 32768
`define TCPM_RESP_OK 2'h0
`define TCPM_RESP_ERR 2'h2
`endif

// *** inc/tcpm_pkg.sv ***
`default_nettype none
package tcpm_pkg;
   typedef enum logic [2:0] {
      TCPM_W_CAT = 3'h0,
      TCPM_W_RTC = 3'h1,
      TCPM_W_SPLIT = 3'h4
   } tcpm_width_t;
   typedef enum logic [1:0] {
      TCPM_E_RISE = 2'h0,
      TCPM_E_FALL = 2'h1,
      TCPM_E_RSVD = 2'h2,
      TCPM_E_BOTH = 2'h3
   } tcpm_edge_t;
   typedef struct packed {
      logic wot;
      logic ams;
      logic cmr;
      logic [1:0] mr;
   } tcpm_mode_t;
   typedef struct packed {
      logic tmr;
      logic ecnt;
      logic etim;
      logic pwm;
   } tcpm_kind_t;
endpackage
`default_nettype wire

// *** src/tcpm_timer.sv ***
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tcpm_map.svh"
module tcpm_timer #(
   parameter int unsigned RTC_DIV = `TCPM_RTC_DIV
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Capture pins, bit 0 is the even pin
   input wire logic [1:0] ccp_in,
   output logic [1:0] pwm_out,
   // Daisy chain and system
   input wire logic trig_in,
   output logic trig_out,
   input wire logic dbg_halt,
   output logic irq,
   output logic adc_trig
);
   localparam int HS = `TCPM_CTL_HALF;
   localparam logic [15:0] DIV_TOP = 16'(RTC_DIV - 1);

   if (RTC_DIV < 2 || RTC_DIV > 65536) begin : g_chk
      $error("RTC_DIV out of range");
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   tcpm_pkg::tcpm_width_t cfg_q;
   tcpm_pkg::tcpm_mode_t mr_q [2];
   tcpm_pkg::tcpm_kind_t kd [2];
   logic [15:0] ctl_q, imr_q, ris_q, set_v;
   logic [15:0] ilr_q [2];
   logic [15:0] mt_q [2];
   logic [15:0] cnt_q [2];
   logic [15:0] cap_q [2];
   logic [15:0] fr_q [2];
   logic [7:0] pr_q [2];
   logic [7:0] pmr_q [2];
   logic [7:0] pre_q [2];
   logic [23:0] nxt [2];
   logic [15:0] trv [2];
   logic [15:0] tvv [2];
   logic [1:0] s1_q, s2_q, s3_q, rise, fall, edg;
   logic [1:0] en, start, stall, go, to_ev, cm_ev, ce_ev, clr_en;
   logic [1:0] run_q, en_prev_q, trig_src, pwm_lv_q, pwm_lv;
   logic [15:0] div_q;
   logic rtc_seen_q, split, rtc, cat, rtc_tick, rtc_hit;
   logic [31:0] pair, rtc_nxt;
   // Bus side
   logic aw_v_q, w_v_q, do_wr, wr_ok, rd_ok;
   logic [7:0] aw_a_q;
   logic [31:0] w_d_q, rd_d;
   logic [3:0] w_s_q;

   function automatic logic [31:0] wmrg(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[8*b +: 8] = d[8*b +: 8];
         end
      end
      return r;
   endfunction

   // ----------------------------------------
   // Pin synchroniser
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_q <= 2'h0;
         s2_q <= 2'h0;
         s3_q <= 2'h0;
      end else begin
         s1_q <= ccp_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // ----------------------------------------
   // Mode decode and events
   // ----------------------------------------
   always_comb begin
      rise = s2_q & ~s3_q;
      fall = ~s2_q & s3_q;
      split = (cfg_q == tcpm_pkg::TCPM_W_SPLIT);
      rtc = (cfg_q == tcpm_pkg::TCPM_W_RTC);
      cat = (cfg_q == tcpm_pkg::TCPM_W_CAT);
      pair = {cnt_q[1], cnt_q[0]};
      set_v = 16'h0;
      for (int h = 0; h < 2; h++) begin
         kd[h].tmr = ((h == 0) ? (split || cat) : split) && !mr_q[h].ams
            && (mr_q[h].mr == `TCPM_MR_ONESHOT
            || mr_q[h].mr == `TCPM_MR_PERIODIC);
         kd[h].ecnt = split && !mr_q[h].ams && !mr_q[h].cmr
            && mr_q[h].mr == `TCPM_MR_CAPTURE;
         kd[h].etim = split && !mr_q[h].ams && mr_q[h].cmr
            && mr_q[h].mr == `TCPM_MR_CAPTURE;
         kd[h].pwm = split && mr_q[h].ams && !mr_q[h].cmr
            && (mr_q[h].mr == `TCPM_MR_ONESHOT
            || mr_q[h].mr == `TCPM_MR_PERIODIC);
         en[h] = ctl_q[HS*h + `TCPM_CTL_EN];
         start[h] = en[h] && !en_prev_q[h];
         stall[h] = ctl_q[HS*h + `TCPM_CTL_STALL] && dbg_halt
            && !(h == 0 && rtc && ctl_q[`TCPM_CTL_RTC_STALL_OVERRIDE_BIT]);
         case (tcpm_pkg::tcpm_edge_t'(ctl_q[HS*h + `TCPM_CTL_EVT +: 2]))
            tcpm_pkg::TCPM_E_RISE: edg[h] = rise[h];
            tcpm_pkg::TCPM_E_FALL: edg[h] = fall[h];
            tcpm_pkg::TCPM_E_BOTH: edg[h] = rise[h] | fall[h];
            default: edg[h] = 1'b0;
         endcase
         go[h] = en[h] && run_q[h] && !stall[h] && !start[h];
         nxt[h] = {pre_q[h], cnt_q[h]} - 24'h1;
         to_ev[h] = kd[h].tmr && go[h]
            && ((cat && h == 0) ? pair == 32'h0 : cnt_q[h] == 16'h0);
         cm_ev[h] = kd[h].ecnt && go[h] && edg[h]
            && nxt[h] == {pmr_q[h], mt_q[h]};
         ce_ev[h] = kd[h].etim && go[h] && edg[h];
         clr_en[h] = (to_ev[h] && mr_q[h].mr == `TCPM_MR_ONESHOT)
            || cm_ev[h];
         trv[h] = kd[h].etim ? cap_q[h] : cnt_q[h];
         tvv[h] = kd[h].ecnt ? fr_q[h] : cnt_q[h];
         pwm_lv[h] = (cnt_q[h] == ilr_q[h]) ? 1'b1 :
            (cnt_q[h] == mt_q[h]) ? 1'b0 : pwm_lv_q[h];
         set_v[HS*h + `TCPM_ST_TO] = to_ev[h];
         set_v[HS*h + `TCPM_ST_CM] = cm_ev[h];
         set_v[HS*h + `TCPM_ST_CE] = ce_ev[h];
      end
      trig_src[0] = trig_in;
      trig_src[1] = split && to_ev[0];
      rtc_tick = rtc && en[0] && !stall[0] && !start[0] && rise[0]
         && div_q == DIV_TOP;
      rtc_nxt = pair + 32'h1;
      rtc_hit = rtc_tick && rtc_nxt == {mt_q[1], mt_q[0]};
      set_v[`TCPM_ST_RTC] = rtc_hit;
   end

   // ----------------------------------------
   // Trigger wait and enable history
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_q <= 2'h0;
         en_prev_q <= 2'h0;
      end else begin
         en_prev_q <= en;
         for (int h = 0; h < 2; h++) begin
            if (start[h]) begin
               run_q[h] <= !mr_q[h].wot || rtc;
            end else if (!en[h]) begin
               run_q[h] <= 1'b0;
            end else if (trig_src[h]) begin
               run_q[h] <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // RTC prescaler
   // ----------------------------------------
   // Only rising edges of the slow clock advance it, so no fast-clock count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_q <= 16'h0;
      end else if (!rtc || start[0]) begin
         div_q <= 16'h0;
      end else if (en[0] && !stall[0] && rise[0]) begin
         div_q <= (div_q == DIV_TOP) ? 16'h0 : div_q + 16'h1;
      end
   end

   // ----------------------------------------
   // Counters
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rtc_seen_q <= 1'b0;
         for (int h = 0; h < 2; h++) begin
            cnt_q[h] <= `TCPM_RST_CNT;
            cap_q[h] <= `TCPM_RST_CNT;
            fr_q[h] <= `TCPM_RST_CNT;
            pre_q[h] <= `TCPM_RST_PR;
         end
      end else if (rtc) begin
         if (start[0]) begin
            rtc_seen_q <= 1'b1;
            {cnt_q[1], cnt_q[0]} <= rtc_seen_q ?
               {ilr_q[1], ilr_q[0]} : `TCPM_RTC_FIRST;
         end else if (rtc_tick) begin
            {cnt_q[1], cnt_q[0]} <= rtc_nxt;
         end
      end else if (cat) begin
         if (start[0]) begin
            {cnt_q[1], cnt_q[0]} <= {ilr_q[1], ilr_q[0]};
         end else if (kd[0].tmr && go[0]) begin
            {cnt_q[1], cnt_q[0]} <= (pair == 32'h0) ?
               {ilr_q[1], ilr_q[0]} : pair - 32'h1;
         end
      end else begin
         for (int h = 0; h < 2; h++) begin
            if (start[h]) begin
               cnt_q[h] <= ilr_q[h];
               fr_q[h] <= ilr_q[h];
               pre_q[h] <= kd[h].ecnt ? pr_q[h] : `TCPM_RST_PR;
            end else if (kd[h].ecnt) begin
               if (go[h]) begin
                  fr_q[h] <= fr_q[h] - 16'h1;
               end
               if (cm_ev[h]) begin
                  {pre_q[h], cnt_q[h]} <= {pr_q[h], ilr_q[h]};
               end else if (go[h] && edg[h]) begin
                  {pre_q[h], cnt_q[h]} <= nxt[h];
               end
            end else if (go[h] && (kd[h].tmr || kd[h].etim
                  || kd[h].pwm)) begin
               cnt_q[h] <= (cnt_q[h] == 16'h0) ? ilr_q[h]
                  : cnt_q[h] - 16'h1;
               if (ce_ev[h]) begin
                  cap_q[h] <= cnt_q[h];
               end
            end
         end
      end
   end

   // ----------------------------------------
   // Outputs: PWM, trigger, ADC, interrupt
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwm_lv_q <= 2'h0;
         pwm_out <= 2'h0;
         trig_out <= 1'b0;
         adc_trig <= 1'b0;
         irq <= 1'b0;
      end else begin
         for (int h = 0; h < 2; h++) begin
            pwm_lv_q[h] <= kd[h].pwm && en[h] && pwm_lv[h];
            pwm_out[h] <= (kd[h].pwm && en[h] && pwm_lv[h])
               ^ ctl_q[HS*h + `TCPM_CTL_PWML];
         end
         trig_out <= split ? to_ev[1] : to_ev[0];
         adc_trig <= |((to_ev | cm_ev | ce_ev)
            & {ctl_q[HS + `TCPM_CTL_OTE], ctl_q[`TCPM_CTL_OTE]});
         irq <= |(ris_q & imr_q);
      end
   end

   // ----------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------
   assign do_wr = aw_v_q && w_v_q && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_v_q <= 1'b0;
         w_v_q <= 1'b0;
         aw_a_q <= 8'h0;
         w_d_q <= 32'h0;
         w_s_q <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TCPM_RESP_OK;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_v_q <= 1'b1;
            aw_a_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_v_q <= 1'b1;
            w_d_q <= s_axi_wdata;
            w_s_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `TCPM_RESP_OK : `TCPM_RESP_ERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_v_q <= 1'b0;
            w_v_q <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Value and readback registers are read-only
   always_comb begin
      case (aw_a_q & `TCPM_PAIR_MASK)
         `TCPM_OFF_ILR, `TCPM_OFF_MT, `TCPM_OFF_PR, `TCPM_OFF_PMR:
            wr_ok = 1'b1;
         default: wr_ok = aw_a_q == `TCPM_OFF_CFG
            || aw_a_q == `TCPM_OFF_AMR || aw_a_q == `TCPM_OFF_BMR
            || aw_a_q == `TCPM_OFF_CTL || aw_a_q == `TCPM_OFF_IMR
            || aw_a_q == `TCPM_OFF_ICR;
      endcase
   end

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q <= tcpm_pkg::TCPM_W_CAT;
         imr_q <= 16'h0;
         for (int h = 0; h < 2; h++) begin
            mr_q[h] <= '0;
            ilr_q[h] <= `TCPM_RST_CNT;
            mt_q[h] <= `TCPM_RST_CNT;
            pr_q[h] <= `TCPM_RST_PR;
            pmr_q[h] <= `TCPM_RST_PR;
         end
      end else if (do_wr) begin
         if (aw_a_q == `TCPM_OFF_CFG) begin
            cfg_q <= tcpm_pkg::tcpm_width_t'(
               3'(wmrg({29'h0, cfg_q}, w_d_q, w_s_q)));
         end
         if (aw_a_q == `TCPM_OFF_IMR) begin
            imr_q <= 16'(wmrg({16'h0, imr_q}, w_d_q, w_s_q));
         end
         for (int h = 0; h < 2; h++) begin
            if (aw_a_q == (h == 0 ? `TCPM_OFF_AMR : `TCPM_OFF_BMR)) begin
               mr_q[h] <= 5'(wmrg({27'h0, mr_q[h]}, w_d_q, w_s_q));
            end
         end
         // In concatenated modes a word at half A of ILR or MT fills both halves
         for (int h = 0; h < 2; h++) begin
            if ((aw_a_q & `TCPM_PAIR_MASK) == `TCPM_OFF_ILR) begin
               if (!split && !aw_a_q[2]) begin
                  ilr_q[h] <= 16'(wmrg({ilr_q[1], ilr_q[0]}, w_d_q,
                     w_s_q) >> (16*h));
               end else if (aw_a_q[2] == h[0]) begin
                  ilr_q[h] <= 16'(wmrg({16'h0, ilr_q[h]}, w_d_q, w_s_q));
               end
            end
            if ((aw_a_q & `TCPM_PAIR_MASK) == `TCPM_OFF_MT) begin
               if (!split && !aw_a_q[2]) begin
                  mt_q[h] <= 16'(wmrg({mt_q[1], mt_q[0]}, w_d_q,
                     w_s_q) >> (16*h));
               end else if (aw_a_q[2] == h[0]) begin
                  mt_q[h] <= 16'(wmrg({16'h0, mt_q[h]}, w_d_q, w_s_q));
               end
            end
            if (aw_a_q == (`TCPM_OFF_PR | {5'h0, h[0], 2'h0})) begin
               pr_q[h] <= 8'(wmrg({24'h0, pr_q[h]}, w_d_q, w_s_q));
            end
            if (aw_a_q == (`TCPM_OFF_PMR | {5'h0, h[0], 2'h0})) begin
               pmr_q[h] <= 8'(wmrg({24'h0, pmr_q[h]}, w_d_q, w_s_q));
            end
         end
      end
   end

   // ----------------------------------------
   // Control register with hardware clears
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_q <= 16'h0;
      end else begin
         ctl_q <= (do_wr && aw_a_q == `TCPM_OFF_CTL) ?
            16'(wmrg({16'h0, ctl_q}, w_d_q, w_s_q)) : ctl_q;
         for (int h = 0; h < 2; h++) begin
            if (clr_en[h]) begin
               ctl_q[HS*h + `TCPM_CTL_EN] <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------
   // Raw status, write one to clear
   // ----------------------------------------
   // A new event in the clearing cycle survives the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ris_q <= 16'h0;
      end else if (do_wr && aw_a_q == `TCPM_OFF_ICR) begin
         ris_q <= (ris_q & ~16'(wmrg(32'h0, w_d_q, w_s_q)))
            | set_v;
      end else begin
         ris_q <= ris_q | set_v;
      end
   end

   // ----------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------
   always_comb begin
      rd_d = 32'h0;
      rd_ok = 1'b1;
      case (s_axi_araddr & `TCPM_PAIR_MASK)
         `TCPM_OFF_ILR: rd_d = (!split && !s_axi_araddr[2]) ?
            {ilr_q[1], ilr_q[0]} : {16'h0, ilr_q[s_axi_araddr[2]]};
         `TCPM_OFF_MT: rd_d = (!split && !s_axi_araddr[2]) ?
            {mt_q[1], mt_q[0]} : {16'h0, mt_q[s_axi_araddr[2]]};
         `TCPM_OFF_PR: rd_d = {24'h0, pr_q[s_axi_araddr[2]]};
         `TCPM_OFF_PMR: rd_d = {24'h0, pmr_q[s_axi_araddr[2]]};
         `TCPM_OFF_TR: rd_d = (!split && !s_axi_araddr[2]) ?
            pair : {16'h0, trv[s_axi_araddr[2]]};
         `TCPM_OFF_TV: rd_d = (!split && !s_axi_araddr[2]) ?
            pair : {16'h0, tvv[s_axi_araddr[2]]};
         default: begin
            case (s_axi_araddr)
               `TCPM_OFF_CFG: rd_d = {29'h0, cfg_q};
               `TCPM_OFF_AMR: rd_d = {27'h0, mr_q[0]};
               `TCPM_OFF_BMR: rd_d = {27'h0, mr_q[1]};
               `TCPM_OFF_CTL: rd_d = {16'h0, ctl_q};
               `TCPM_OFF_IMR: rd_d = {16'h0, imr_q};
               `TCPM_OFF_RIS: rd_d = {16'h0, ris_q};
               `TCPM_OFF_MIS: rd_d = {16'h0, ris_q & imr_q};
               `TCPM_OFF_ICR: rd_d = 32'h0;
               default: rd_ok = 1'b0;
            endcase
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `TCPM_RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_d;
         s_axi_rresp <= rd_ok ? `TCPM_RESP_OK : `TCPM_RESP_ERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// *** verif/tcpm_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcpm_pin_model (
   // Clock and request
   input wire logic aclk,
   input wire logic go,
   input wire logic [7:0] n,
   // Pin side
   output logic pin,
   output logic busy
);
   logic [9:0] cnt_q;
   initial begin
      pin = 1'b0;
      cnt_q = 10'h000;
   end
   // Four clocks a level keeps the edge rate legal
   always @(posedge aclk) begin
      if (go)
         cnt_q <= {n, 2'h0};
      else if (cnt_q != 10'h000) begin
         cnt_q <= cnt_q - 10'h001;
         if (cnt_q[1:0] == 2'h1)
            pin <= ~pin;
      end
   end
   assign busy = (cnt_q != 10'h000);
endmodule
`default_nettype wire

// *** verif/tcpm_timer_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcpm_timer_checker (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Events
   input wire logic trig_out,
   input wire logic adc_trig
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wtake;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rtake;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_b_after; s_wtake |-> ##2 s_axi_bvalid; endproperty
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   property p_r_after; s_rtake |=> s_axi_rvalid; endproperty
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
   endproperty
   property p_w_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   property p_r_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
   property p_trig; trig_out |=> !trig_out; endproperty
   property p_adc; adc_trig |=> !adc_trig; endproperty
   a_b_after: assert property (p_b_after) else $error("no write answer");
   a_b_hold: assert property (p_b_hold) else $error("write answer lost");
   a_r_after: assert property (p_r_after) else $error("no read answer");
   a_r_hold: assert property (p_r_hold) else $error("read answer lost");
   a_w_busy: assert property (p_w_busy) else $error("write ready early");
   a_r_busy: assert property (p_r_busy) else $error("read ready early");
   a_trig: assert property (p_trig) else $error("chain pulse long");
   a_adc: assert property (p_adc) else $error("trigger pulse long");
endmodule
bind tcpm_timer tcpm_timer_checker u_chk (.*);
`default_nettype wire

// *** verif/tcpm_timer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcpm_timer_tb;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, trig_in, dbg_halt, go, busy, pin;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, trig_out, irq, adc_trig;
   logic [7:0] s_axi_awaddr, s_axi_araddr, n;
   logic [31:0] s_axi_wdata, s_axi_rdata, d, e;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs, bs, ccp_in, pwm_out;
   int n_fail, checks_done, cyc, h, n_adc;
   tcpm_timer #(.RTC_DIV(4)) u_dut (.*);
   tcpm_pin_model u_pin (.aclk(aclk), .go(go), .n(n), .pin(pin),
      .busy(busy));
   assign ccp_in = {1'b0, pin};
   // ------
   // Clock, timeout and checks
   // ------
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (adc_trig) n_adc++;
      if (cyc == 20000) begin
         n_fail++;
         summarize();
      end
   end
   task summarize;
      $display("fails %0d checks %0d", n_fail, checks_done);
      if (n_fail == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] x);
      checks_done++;
      if (g !== x) begin
         n_fail++;
         $display("unexpected %0t got %h want %h", $time, g, x);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      bs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      v = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task rc(input logic [7:0] a, input logic [31:0] x);
      rd(a, d);
      chk(d, x);
   endtask
   task edges(input logic [7:0] k);
      @(posedge aclk);
      go <= 1'b1;
      n <= k;
      @(posedge aclk);
      go <= 1'b0;
      do @(posedge aclk); while (busy);
      repeat (8) @(posedge aclk);
   endtask
   task duty(input int x);
      repeat (20) @(posedge aclk);
      h = 0;
      repeat (18) begin
         @(posedge aclk);
         h = h + pwm_out[0];
      end
      chk(h, x);
   endtask
   // ------
   // Main sequence
   // ------
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, trig_in, dbg_halt, go, aresetn} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, n} = '0;
      s_axi_wstrb = 4'hf;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rc(8'h48, 32'hffffffff);
      rc(8'hfc, 32'h0);
      chk(rs, 2'h2);
      wr(8'h50, 32'h0);
      chk(bs, 2'h2);
      wr(8'h00, 32'h4);
      chk(bs, 2'h0);
      wr(8'h04, 32'h3);
      wr(8'h28, 32'ha);
      wr(8'h30, 32'h6);
      wr(8'h18, 32'h2);
      wr(8'h0c, 32'h2d);
      edges(8'h06);
      rc(8'h1c, 32'h2);
      chk(irq, 1'b1);
      chk(n_adc, 1);
      rc(8'h0c, 32'h2c);
      rc(8'h48, 32'ha);
      wr(8'h24, 32'hffff);
      wr(8'h04, 32'h7);
      wr(8'h28, 32'hffff);
      wr(8'h0c, 32'h1);
      edges(8'h02);
      rc(8'h1c, 32'h4);
      rd(8'h48, d);
      rd(8'h48, e);
      chk(e, d);
      rd(8'h50, e);
      chk(e !== d, 1'b1);
      wr(8'h0c, 32'h0);
      wr(8'h04, 32'ha);
      wr(8'h28, 32'h8);
      wr(8'h30, 32'h3);
      wr(8'h24, 32'hffff);
      wr(8'h0c, 32'h1);
      duty(10);
      wr(8'h0c, 32'h41);
      duty(8);
      rc(8'h1c, 32'h0);
      wr(8'h0c, 32'h0);
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h1);
      wr(8'h30, 32'h2);
      wr(8'h18, 32'h8);
      wr(8'h0c, 32'h13);
      dbg_halt <= 1'b1;
      edges(8'h08);
      dbg_halt <= 1'b0;
      rc(8'h1c, 32'h8);
      chk(irq, 1'b1);
      rc(8'h48, 32'h2);
      wr(8'h24, 32'h8);
      rc(8'h1c, 32'h0);
      chk(irq, 1'b0);
      wr(8'h0c, 32'h0);
      wr(8'h00, 32'h4);
      // Not first in chain: trig_in stands for an earlier module
      wr(8'h04, 32'h12);
      wr(8'h08, 32'h11);
      wr(8'h28, 32'h3);
      wr(8'h2c, 32'h2);
      wr(8'h24, 32'hffff);
      wr(8'h0c, 32'h101);
      repeat (10) @(posedge aclk);
      rc(8'h1c, 32'h0);
      trig_in <= 1'b1;
      @(posedge aclk);
      trig_in <= 1'b0;
      h = 0;
      repeat (40) begin
         @(posedge aclk);
         h = h | trig_out;
      end
      chk(h, 1);
      rc(8'h1c, 32'h101);
      summarize();
   end
endmodule
`default_nettype wire
